//--- rtl/dmb_pkg.sv
package dmb_pkg;
  // ==========================================================
  // apb register map
  localparam logic [11:0] REG_CTRL  = 12'h000;
  localparam logic [11:0] REG_PC    = 12'h004;
  localparam logic [11:0] REG_STAT  = 12'h008;
  // ctrl fields
  localparam int CTRL_BE_BIT  = 0;
  localparam int CTRL_RBE_BIT = 1;
  localparam int CTRL_BS_LSB  = 4;
  localparam int CTRL_SB_LSB  = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // stat fields
  localparam int STAT_ERR_BIT  = 16;
  localparam int STAT_AREA_LSB = 18;
  // ==========================================================
  // memory map
  localparam int          RAM_WORDS   = 768;
  localparam int          PER_WORDS   = 128;
  localparam logic [11:0] GPREG_LAST  = 12'h01f;
  localparam logic [11:0] DISP_FIRST  = 12'h1ec;
  localparam logic [11:0] DISP_LAST   = 12'h1ff;
  localparam logic [11:0] DATA_LAST   = 12'h2ff;
  localparam logic [11:0] PER_FIRST   = 12'hf80;
  localparam logic [3:0]  BANK_PER    = 4'hf;
  localparam logic [3:0]  BANK_MAXRAM = 4'h2;
  localparam logic [1:0]  STACK_MAX   = 2'h2;
  localparam logic [7:0]  FMEM_LO0    = 8'hb0;
  localparam logic [7:0]  FMEM_HI0    = 8'hbf;
  localparam logic [7:0]  FMEM_LO1    = 8'hf0;
  localparam logic [1:0]  PMEM_TOP    = 2'h3;
  localparam logic [6:0]  TADDR_LO    = 7'h20;
  localparam logic [13:0] VEC_RESET   = 14'h0000;
  localparam int          VEC_BE_BIT  = 7;
  localparam int          VEC_RBE_BIT = 6;
  localparam logic signed [5:0] REL_MIN_NEG = -6'sd15;
  localparam logic signed [5:0] REL_MAX_NEG = -6'sd1;
  localparam logic signed [5:0] REL_MIN_POS = 6'sd2;
  localparam logic signed [5:0] REL_MAX_POS = 6'sd16 - 6'sd0;
  // ==========================================================
  // request modes
  localparam logic [3:0] MODE_DIRECT  = 4'h0;
  localparam logic [3:0] MODE_IND_HL  = 4'h1;
  localparam logic [3:0] MODE_IND_DE  = 4'h2;
  localparam logic [3:0] MODE_IND_DL  = 4'h3;
  localparam logic [3:0] MODE_FMEM    = 4'h4;
  localparam logic [3:0] MODE_PMEM    = 4'h5;
  localparam logic [3:0] MODE_ABS     = 4'h6;
  localparam logic [3:0] MODE_REL     = 4'h7;
  localparam logic [3:0] MODE_CADDR   = 4'h8;
  localparam logic [3:0] MODE_FADDR   = 4'h9;
  localparam logic [3:0] MODE_TADDR   = 4'ha;
  localparam logic [3:0] MODE_PAIR_RD = 4'hb;
  localparam logic [3:0] MODE_PAIR_WR = 4'hc;

  typedef enum logic [2:0] {
    AREA_NONE  = 3'h0,
    AREA_GPREG = 3'h1,
    AREA_DATA  = 3'h2,
    AREA_DISP  = 3'h3,
    AREA_PER   = 3'h4,
    AREA_PROG  = 3'h5,
    AREA_PAIR  = 3'h6
  } dmb_area_t;

  typedef enum logic [3:0] {
    ST_FETCH0 = 4'b0001,
    ST_FETCH1 = 4'b0010,
    ST_FETCH2 = 4'b0100,
    ST_RUN    = 4'b1000
  } dmb_state_t;

  typedef struct packed {
    logic [3:0]  mode;
    logic [13:0] operand;
    logic [1:0]  bitNum;
    logic        isBit;
    logic        wide;
    logic        write;
    logic [7:0]  wdata;
    logic [2:0]  pairSel;
    logic [3:0]  regD;
    logic [3:0]  regE;
    logic [3:0]  regH;
    logic [3:0]  regL;
  } dmb_req_t;

  typedef struct packed {
    logic [11:0] dataAddr;
    logic [13:0] progAddr;
    dmb_area_t   area;
    logic [7:0]  rdata;
    logic        bitVal;
    logic        err;
  } dmb_rsp_t;
endpackage

//--- rtl/dmb_ram.sv
`timescale 1ns/1ps
`default_nettype none
module dmb_ram (
  input  wire logic       clk,
  input  wire logic       ce,
  input  wire logic [9:0] addr,
  input  wire logic       we,
  input  wire logic       wide,
  input  wire logic [3:0] bitMask,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata
);
  // ==========================================================
  // storage
  logic [3:0] mem [dmb_pkg::RAM_WORDS];
  logic [9:0] addrOdd;

  assign addrOdd = addr | 10'h001;

  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[addr] <= (mem[addr] & ~bitMask) | (wdata[3:0] & bitMask);
      if (wide) begin
        mem[addrOdd] <= wdata[7:4];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      rdata <= {mem[addrOdd], mem[addr]};
    end
  end
endmodule
`default_nettype wire

//--- rtl/dmb_addressing.sv
`timescale 1ns/1ps
`default_nettype none
module dmb_addressing (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              reqValid,
  output logic                   reqReady,
  input  wire dmb_pkg::dmb_req_t req,
  output logic                   rspValid,
  output dmb_pkg::dmb_rsp_t      rsp,
  input  wire logic              pcStep,
  output logic      [13:0]       romAddr,
  input  wire logic [7:0]        romData,
  output logic                   perSel,
  output logic      [6:0]        perAddr,
  output logic                   perWe,
  output logic      [3:0]        perBitMask,
  output logic      [7:0]        perWdata,
  input  wire logic [7:0]        perRdata,
  output logic      [11:0]       stackBase,
  output logic                   regbankEnable
);
  // ==========================================================
  // state
  dmb_pkg::dmb_state_t state_q;
  logic [31:0]         ctrl_q;
  logic [13:0]         pc_q;
  logic [7:0]          vec0_q;
  logic [7:0]          pairFile_q [8];
  logic                rspValid_q;
  logic [11:0]         dataAddr_q;
  logic [13:0]         progAddr_q;
  dmb_pkg::dmb_area_t  area_q;
  logic                err_q;
  logic [3:0]          mode_q;
  logic [1:0]          bitNum_q;
  logic [7:0]          pairData_q;
  logic [7:0]          perData_q;

  logic                bankEnable;
  logic [3:0]          bankSel;
  logic [1:0]          stackBank;
  logic                take;
  logic [3:0]          activeBank;
  logic [11:0]         dataAddr;
  logic [13:0]         progAddr;
  dmb_pkg::dmb_area_t  area;
  logic                err;
  logic                isData;
  logic [1:0]          bitNum;
  logic [3:0]          bitMask;
  logic [7:0]          ramRdata;
  logic                apbWr;
  logic                ctrlWr;
  logic signed [5:0]   relOff;
  logic [13:0]         relTgt;
  logic [3:0]          wrBank;
  logic [1:0]          wrStack;

  assign bankEnable    = ctrl_q[dmb_pkg::CTRL_BE_BIT];
  assign bankSel       = ctrl_q[dmb_pkg::CTRL_BS_LSB +: 4];
  assign stackBank     = ctrl_q[dmb_pkg::CTRL_SB_LSB +: 2];
  assign regbankEnable = ctrl_q[dmb_pkg::CTRL_RBE_BIT];
  assign stackBase     = {2'h0, stackBank, 8'h00};
  assign reqReady      = ce && (state_q == dmb_pkg::ST_RUN);
  assign take          = reqValid && reqReady;
  assign romAddr       = pc_q;
  assign relOff        = req.operand[5:0];
  assign relTgt        = pc_q + {{8{relOff[5]}}, relOff};

  // ==========================================================
  // address formation
  always_comb begin
    activeBank = 4'h0;
    dataAddr   = 12'h000;
    progAddr   = 14'h0000;
    err        = 1'b0;
    isData     = 1'b1;
    bitNum     = req.bitNum;
    case (req.mode)
      dmb_pkg::MODE_DIRECT: begin
        if (bankEnable) begin
          activeBank = bankSel;
        end else begin
          activeBank = req.operand[7] ? dmb_pkg::BANK_PER : 4'h0;
        end
        dataAddr = {activeBank, req.operand[7:0]};
      end
      dmb_pkg::MODE_IND_HL: begin
        activeBank = bankEnable ? bankSel : 4'h0;
        if (req.isBit) begin
          dataAddr = {activeBank, req.regH, req.operand[3:0]};
        end else begin
          dataAddr = {activeBank, req.regH, req.regL};
        end
      end
      dmb_pkg::MODE_IND_DE: begin
        dataAddr = {4'h0, req.regD, req.regE};
      end
      dmb_pkg::MODE_IND_DL: begin
        dataAddr = {4'h0, req.regD, req.regL};
      end
      dmb_pkg::MODE_FMEM: begin
        dataAddr = {dmb_pkg::BANK_PER, req.operand[7:0]};
        err      = !((req.operand[7:0] >= dmb_pkg::FMEM_LO0 && req.operand[7:0] <= dmb_pkg::FMEM_HI0) ||
                     req.operand[7:0] >= dmb_pkg::FMEM_LO1);
      end
      dmb_pkg::MODE_PMEM: begin
        dataAddr = {dmb_pkg::BANK_PER, req.operand[7:2], req.operand[1:0] | req.regL[3:2]};
        bitNum   = req.regL[1:0];
        err      = req.operand[7:6] != dmb_pkg::PMEM_TOP;
      end
      dmb_pkg::MODE_ABS: begin
        isData   = 1'b0;
        progAddr = req.operand;
      end
      dmb_pkg::MODE_REL: begin
        isData   = 1'b0;
        progAddr = relTgt;
        err      = !((relOff >= dmb_pkg::REL_MIN_NEG && relOff <= dmb_pkg::REL_MAX_NEG) ||
                     (relOff >= dmb_pkg::REL_MIN_POS && relOff <= dmb_pkg::REL_MAX_POS));
      end
      dmb_pkg::MODE_CADDR: begin
        isData   = 1'b0;
        progAddr = {pc_q[13:12], req.operand[11:0]};
      end
      dmb_pkg::MODE_FADDR: begin
        isData   = 1'b0;
        progAddr = {3'h0, req.operand[10:0]};
      end
      dmb_pkg::MODE_TADDR: begin
        isData   = 1'b0;
        progAddr = {7'h00, req.operand[6:1], 1'b0};
        err      = req.operand[13:7] != 7'h00 || req.operand[6:0] < dmb_pkg::TADDR_LO || req.operand[0];
      end
      dmb_pkg::MODE_PAIR_RD, dmb_pkg::MODE_PAIR_WR: begin
        isData = 1'b0;
      end
      default: begin
        isData = 1'b0;
        err    = 1'b1;
      end
    endcase
    if (isData && req.wide && dataAddr[0]) begin
      err = 1'b1;
    end
  end

  // area decode
  always_comb begin
    area = dmb_pkg::AREA_NONE;
    if (!isData) begin
      if (req.mode == dmb_pkg::MODE_PAIR_RD || req.mode == dmb_pkg::MODE_PAIR_WR) begin
        area = dmb_pkg::AREA_PAIR;
      end else begin
        area = dmb_pkg::AREA_PROG;
      end
    end else if (dataAddr <= dmb_pkg::GPREG_LAST) begin
      area = dmb_pkg::AREA_GPREG;
    end else if (dataAddr >= dmb_pkg::DISP_FIRST && dataAddr <= dmb_pkg::DISP_LAST) begin
      area = dmb_pkg::AREA_DISP;
    end else if (dataAddr <= dmb_pkg::DATA_LAST) begin
      area = dmb_pkg::AREA_DATA;
    end else if (dataAddr >= dmb_pkg::PER_FIRST) begin
      area = dmb_pkg::AREA_PER;
    end
  end

  assign bitMask = req.isBit ? (4'h1 << bitNum) : 4'hf;

  // ==========================================================
  // memories
  dmb_ram u_ram (
    .clk     (clk),
    .ce      (ce),
    .addr    (dataAddr[9:0]),
    .we      (take && req.write && !err && isData && area != dmb_pkg::AREA_PER && area != dmb_pkg::AREA_NONE),
    .wide    (req.wide),
    .bitMask (bitMask),
    .wdata   (req.wdata),
    .rdata   (ramRdata)
  );

  assign perSel     = take && !err && area == dmb_pkg::AREA_PER;
  assign perAddr    = dataAddr[6:0];
  assign perWe      = perSel && req.write;
  assign perBitMask = bitMask;
  assign perWdata   = req.wdata;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        pairFile_q[i] <= 8'h00;
      end
    end else if (ce && take && req.mode == dmb_pkg::MODE_PAIR_WR) begin
      pairFile_q[req.pairSel] <= req.wdata;
    end
  end

  // ==========================================================
  // response
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rspValid_q <= 1'b0;
      dataAddr_q <= 12'h000;
      progAddr_q <= 14'h0000;
      area_q     <= dmb_pkg::AREA_NONE;
      err_q      <= 1'b0;
      mode_q     <= dmb_pkg::MODE_DIRECT;
      bitNum_q   <= 2'h0;
      pairData_q <= 8'h00;
      perData_q  <= 8'h00;
    end else if (ce) begin
      rspValid_q <= take;
      if (take) begin
        dataAddr_q <= dataAddr;
        progAddr_q <= progAddr;
        area_q     <= area;
        err_q      <= err || (isData && area == dmb_pkg::AREA_NONE);
        mode_q     <= req.mode;
        bitNum_q   <= bitNum;
        pairData_q <= pairFile_q[req.pairSel];
        perData_q  <= perRdata;
      end
    end
  end

  always_comb begin
    rsp.dataAddr = dataAddr_q;
    rsp.progAddr = progAddr_q;
    rsp.area     = area_q;
    rsp.err      = err_q;
    case (area_q)
      dmb_pkg::AREA_PER:  rsp.rdata = perData_q;
      dmb_pkg::AREA_PAIR: rsp.rdata = pairData_q;
      dmb_pkg::AREA_NONE: rsp.rdata = 8'h00;
      dmb_pkg::AREA_PROG: rsp.rdata = 8'h00;
      default:            rsp.rdata = ramRdata;
    endcase
    rsp.bitVal = rsp.rdata[bitNum_q];
  end
  assign rspValid = rspValid_q;

  // ==========================================================
  // reset vector fetch and program counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= dmb_pkg::ST_FETCH0;
    end else if (ce) begin
      case (state_q)
        dmb_pkg::ST_FETCH0: state_q <= dmb_pkg::ST_FETCH1;
        dmb_pkg::ST_FETCH1: state_q <= dmb_pkg::ST_FETCH2;
        dmb_pkg::ST_FETCH2: state_q <= dmb_pkg::ST_RUN;
        dmb_pkg::ST_RUN:    state_q <= dmb_pkg::ST_RUN;
        default:            state_q <= dmb_pkg::ST_FETCH0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vec0_q <= 8'h00;
    end else if (ce && state_q == dmb_pkg::ST_FETCH1) begin
      vec0_q <= romData;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc_q <= dmb_pkg::VEC_RESET;
    end else if (ce) begin
      case (state_q)
        dmb_pkg::ST_FETCH0: pc_q <= dmb_pkg::VEC_RESET + 14'h0001;
        dmb_pkg::ST_FETCH2: pc_q <= {vec0_q[5:0], romData};
        dmb_pkg::ST_RUN: begin
          if (psel && penable && pwrite && paddr == dmb_pkg::REG_PC) begin
            pc_q <= pwdata[13:0];
          end else if (take && !isData && area == dmb_pkg::AREA_PROG && req.write && !err) begin
            pc_q <= progAddr;
          end else if (pcStep) begin
            pc_q <= pc_q + 14'h0001;
          end
        end
        default: pc_q <= pc_q;
      endcase
    end
  end

  // ==========================================================
  // apb slave and control register
  assign apbWr   = psel && penable && pwrite;
  assign ctrlWr  = apbWr && paddr == dmb_pkg::REG_CTRL;
  assign wrBank  = pwdata[dmb_pkg::CTRL_BS_LSB +: 4];
  assign wrStack = pwdata[dmb_pkg::CTRL_SB_LSB +: 2];
  assign pready  = 1'b1;
  assign pslverr = psel && penable &&
                   !(paddr == dmb_pkg::REG_CTRL || paddr == dmb_pkg::REG_PC ||
                     (paddr == dmb_pkg::REG_STAT && !pwrite));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= dmb_pkg::CTRL_RESET;
    end else if (ce) begin
      if (state_q == dmb_pkg::ST_FETCH2) begin
        ctrl_q[dmb_pkg::CTRL_BE_BIT]  <= vec0_q[dmb_pkg::VEC_BE_BIT];
        ctrl_q[dmb_pkg::CTRL_RBE_BIT] <= vec0_q[dmb_pkg::VEC_RBE_BIT];
      end else if (ctrlWr) begin
        ctrl_q[dmb_pkg::CTRL_BE_BIT]  <= pwdata[dmb_pkg::CTRL_BE_BIT];
        ctrl_q[dmb_pkg::CTRL_RBE_BIT] <= pwdata[dmb_pkg::CTRL_RBE_BIT];
        if (wrBank <= dmb_pkg::BANK_MAXRAM || wrBank == dmb_pkg::BANK_PER) begin
          ctrl_q[dmb_pkg::CTRL_BS_LSB +: 4] <= wrBank;
        end
        if (wrStack <= dmb_pkg::STACK_MAX) begin
          ctrl_q[dmb_pkg::CTRL_SB_LSB +: 2] <= wrStack;
        end
      end
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (psel) begin
      case (paddr)
        dmb_pkg::REG_CTRL: prdata = ctrl_q;
        dmb_pkg::REG_PC:   prdata = {18'h00000, pc_q};
        dmb_pkg::REG_STAT: begin
          prdata[11:0]                          = dataAddr_q;
          prdata[dmb_pkg::STAT_ERR_BIT]         = err_q;
          prdata[dmb_pkg::STAT_AREA_LSB +: 3]   = area_q;
        end
        default:           prdata = 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- testbench/dmb_addressing_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dmb_addressing_sva (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              ce,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              reqValid,
  input wire logic              reqReady,
  input wire dmb_pkg::dmb_req_t req,
  input wire logic              rspValid,
  input wire dmb_pkg::dmb_rsp_t rsp,
  input wire logic              pcStep,
  input wire logic [13:0]       romAddr,
  input wire logic [11:0]       stackBase
);
  // ==========================================================
  // sequences
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence sAny;
    reqValid && reqReady;
  endsequence
  sequence sTake(logic [3:0] m);
    reqValid && reqReady && req.mode == m;
  endsequence
  sequence sPlainBit;
    reqValid && reqReady && req.mode != dmb_pkg::MODE_PMEM;
  endsequence
  // ==========================================================
  // properties
  a_rsp_next: assert property (sAny |=> rspValid) else $error("no response after take");
  a_rsp_lone: assert property (!(reqValid && reqReady) |=> !rspValid) else $error("spare response");
  a_boot_wait: assert property (!$past(rst_n) |-> !reqReady ##1 !reqReady) else $error("ready during boot");
  a_pc_step: assert property (ce && pcStep && reqReady && !reqValid && !(psel && penable)
    |=> romAddr == $past(romAddr) + 14'h1) else $error("pc did not step");
  a_alt_bank: assert property ((sTake(dmb_pkg::MODE_IND_DE) or sTake(dmb_pkg::MODE_IND_DL))
    |=> rsp.dataAddr[11:4] == {4'h0, $past(req.regD)}) else $error("alt pair bank wrong");
  a_fmem_addr: assert property (sTake(dmb_pkg::MODE_FMEM) ##0 (req.operand[7:4] inside {4'hb, 4'hf})
    |=> rsp.dataAddr == {4'hf, $past(req.operand[7:0])} && !rsp.err) else $error("fixed bit addr");
  a_pmem_bank: assert property (sTake(dmb_pkg::MODE_PMEM) ##0 req.operand[7:6] == 2'b11
    |=> rsp.dataAddr[11:6] == 6'h3f && !rsp.err) else $error("indexed bit addr");
  a_bit_pick: assert property (sPlainBit |=> rsp.bitVal == rsp.rdata[$past(req.bitNum)]) else $error("bit pick");
  a_pmem_bit: assert property (sTake(dmb_pkg::MODE_PMEM)
    |=> rsp.bitVal == rsp.rdata[$past(req.regL[1:0])]) else $error("indexed bit pick");
  a_caddr_keep: assert property (sTake(dmb_pkg::MODE_CADDR)
    |=> rsp.progAddr == {$past(romAddr[13:12]), $past(req.operand[11:0])}) else $error("caddr block");
  a_faddr_low: assert property (sTake(dmb_pkg::MODE_FADDR) |=> rsp.progAddr[13:11] == 3'h0) else $error("faddr");
  a_taddr_odd: assert property (sTake(dmb_pkg::MODE_TADDR) ##0 req.operand[0] |=> rsp.err) else $error("odd taddr");
  a_rel_range: assert property (sTake(dmb_pkg::MODE_REL) ##0 (req.operand[5:0] < 6'h02
    || (req.operand[5:0] > 6'h10 && req.operand[5:0] < 6'h31)) |=> rsp.err) else $error("rel range");
  a_stack_bank: assert property (stackBase[7:0] == 8'h00 && stackBase[11:8] <= 4'h2) else $error("stack");
endmodule
bind dmb_addressing dmb_addressing_sva dmb_addressing_sva_inst (.clk(clk), .rst_n(rst_n), .ce(ce),
  .psel(psel), .penable(penable), .reqValid(reqValid), .reqReady(reqReady), .req(req), .rspValid(rspValid),
  .rsp(rsp), .pcStep(pcStep), .romAddr(romAddr), .stackBase(stackBase));
`default_nettype wire

//--- testbench/dmb_cpu_side.sv
`timescale 1ns/1ps
`default_nettype none
module dmb_cpu_side #(
  parameter logic [7:0] VEC_HI = 8'hc1,
  parameter logic [7:0] VEC_LO = 8'h23
) (
  input  wire logic        clk,
  input  wire logic [13:0] romAddr,
  output logic      [7:0]  romData,
  input  wire logic        perSel,
  input  wire logic [6:0]  perAddr,
  output logic      [7:0]  perRdata
);
  // ==========================================================
  // program memory with reset vector
  logic [7:0] cnt = 8'h00;
  always_ff @(posedge clk) begin
    case (romAddr)
      14'h0000: romData <= VEC_HI;
      14'h0001: romData <= VEC_LO;
      default:  romData <= romAddr[7:0] ^ 8'h3c;
    endcase
    cnt <= cnt + 8'h01;
  end
  // ==========================================================
  // peripheral area, changing pattern when not selected
  assign perRdata = perSel ? {1'b0, perAddr} : cnt;
endmodule
`default_nettype wire

//--- testbench/dmb_addressing_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dmb_addressing_bench;
  typedef struct {logic [1:0] k; logic [13:0] v; logic e;} dmb_exp_t;
  logic clk = 0, rst_n = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, reqValid = 0, pcStep = 0;
  logic [11:0] paddr = 12'h000, stackBase;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, reqReady, rspValid, perSel, regbankEnable, er;
  logic [13:0] romAddr;
  logic [7:0] romData, perRdata, o;
  logic [6:0] perAddr;
  dmb_pkg::dmb_req_t req = '0, r;
  dmb_pkg::dmb_rsp_t rsp;
  dmb_exp_t e, expq[$];
  logic [7:0] pv [8];
  logic [7:0] dops [6] = '{8'h00, 8'h1f, 8'h20, 8'h7f, 8'h80, 8'hff};
  logic [7:0] fops [6] = '{8'hb0, 8'hbf, 8'hf0, 8'hff, 8'hc0, 8'haf};
  logic [5:0] rels [8] = '{6'h10, 6'h02, 6'h3f, 6'h31, 6'h11, 6'h01, 6'h00, 6'h30};
  logic [6:0] tops [4] = '{7'h20, 7'h7e, 7'h21, 7'h1e};
  logic [3:0] bss [4] = '{4'h0, 4'h1, 4'h2, 4'hf};
  int errors = 0, num_checks = 0, cyc = 0;
  always #2.5 clk = ~clk;
  dmb_addressing dmb_addressing_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reqValid(reqValid), .reqReady(reqReady), .req(req), .rspValid(rspValid), .rsp(rsp), .pcStep(pcStep),
    .romAddr(romAddr), .romData(romData), .perSel(perSel), .perAddr(perAddr), .perWe(), .perBitMask(),
    .perWdata(), .perRdata(perRdata), .stackBase(stackBase), .regbankEnable(regbankEnable));
  dmb_cpu_side dmb_cpu_side_inst (.clk(clk), .romAddr(romAddr), .romData(romData), .perSel(perSel),
    .perAddr(perAddr), .perRdata(perRdata));
  // ==========================================================
  // helpers
  function automatic dmb_pkg::dmb_area_t ar(logic [11:0] a);
    if (a <= dmb_pkg::GPREG_LAST) return dmb_pkg::AREA_GPREG;
    if (a >= dmb_pkg::DISP_FIRST && a <= dmb_pkg::DISP_LAST) return dmb_pkg::AREA_DISP;
    if (a <= dmb_pkg::DATA_LAST) return dmb_pkg::AREA_DATA;
    if (a >= dmb_pkg::PER_FIRST) return dmb_pkg::AREA_PER;
    return dmb_pkg::AREA_NONE;
  endfunction
  function automatic dmb_exp_t x(logic [1:0] k, logic [13:0] v, logic ee);
    x.k = k;
    x.v = v;
    x.e = ee;
  endfunction
  task automatic chk(string n, logic [31:0] s, logic [31:0] xv);
    num_checks++;
    if (s !== xv) begin
      errors++;
      $display("BAD %s exp %h seen %h", n, xv, s);
    end
  endtask
  task automatic conclude();
    if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic mk(logic [3:0] m, logic [13:0] op, logic w, logic wd);
    r = dmb_pkg::dmb_req_t'({$urandom, $urandom, $urandom});
    r.mode = m;
    r.operand = op;
    r.write = w;
    r.wide = wd;
    r.isBit = 0;
  endtask
  task automatic go(dmb_exp_t xe);
    reqValid <= 1;
    req <= r;
    expq.push_back(xe);
    @(posedge clk);
    while (reqReady !== 1'b1) @(posedge clk);
  endtask
  task automatic idle();
    reqValid <= 0;
    @(posedge clk);
  endtask
  // ==========================================================
  // response monitor and timeout
  always @(posedge clk) begin
    if (rspValid === 1'b1) begin
      if (expq.size() == 0) chk("spare", 1, 0);
      else begin
        e = expq.pop_front();
        chk("err", rsp.err, e.e);
        if (!e.e && e.k == 0) chk("dataAddr", rsp.dataAddr, e.v[11:0]);
        if (!e.e && e.k == 0) chk("area", rsp.area, ar(e.v[11:0]));
        if (!e.e && e.k == 0 && ar(e.v[11:0]) == dmb_pkg::AREA_PER) chk("per", rsp.rdata, {1'b0, e.v[6:0]});
        if (!e.e && e.k == 1) chk("progAddr", rsp.progAddr, e.v);
        if (!e.e && e.k == 2) chk("rdata", rsp.rdata, e.v[7:0]);
      end
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      conclude();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(90));
    repeat (6) @(posedge clk);
    rst_n <= 1;
    repeat (12) @(posedge clk);
    chk("rbe", regbankEnable, 1);
    apb(0, dmb_pkg::REG_CTRL, 0);
    chk("ctrlVec", rd[1:0], 2'b11);
    apb(0, dmb_pkg::REG_PC, 0);
    chk("pcVec", rd[13:0], 14'h0123);
    apb(0, 12'h00c, 0);
    chk("unmapped", er, 1);
    apb(1, dmb_pkg::REG_CTRL, 32'h200);
    apb(1, dmb_pkg::REG_CTRL, 32'h300);
    foreach (dops[i]) begin
      mk(dmb_pkg::MODE_DIRECT, {6'h0, dops[i]}, 0, 0);
      go(x(0, {2'h0, dops[i][7] ? 4'hf : 4'h0, dops[i]}, 0));
    end
    mk(dmb_pkg::MODE_IND_HL, 0, 0, 0);
    go(x(0, {6'h0, r.regH, r.regL}, 0));
    idle();
    chk("stackBase", stackBase, 12'h200);
    foreach (bss[i]) begin
      apb(1, dmb_pkg::REG_CTRL, {22'h0, 2'h2, bss[i], 4'h1});
      mk(dmb_pkg::MODE_DIRECT, 14'h0ec, 0, 0);
      go(x(0, {2'h0, bss[i], 8'hec}, 0));
      mk(dmb_pkg::MODE_IND_HL, 0, 0, 0);
      go(x(0, {2'h0, bss[i], r.regH, r.regL}, 0));
      mk(dmb_pkg::MODE_IND_DE, 0, 0, 0);
      go(x(0, {6'h0, r.regD, r.regE}, 0));
      mk(dmb_pkg::MODE_IND_DL, 0, 0, 0);
      go(x(0, {6'h0, r.regD, r.regL}, 0));
      idle();
    end
    apb(1, dmb_pkg::REG_CTRL, 32'h231);
    apb(0, dmb_pkg::REG_CTRL, 0);
    chk("bankKeep", rd[7:4], 4'hf);
    foreach (fops[i]) begin
      mk(dmb_pkg::MODE_FMEM, {6'h0, fops[i]}, 0, 0);
      go(x(0, {6'h0f, fops[i]}, !(fops[i][7:4] inside {4'hb, 4'hf})));
    end
    for (int i = 0; i < 5; i++) begin
      o = {i == 4 ? 2'b10 : 2'b11, 6'($urandom)};
      mk(dmb_pkg::MODE_PMEM, {6'h0, o}, 0, 0);
      r.isBit = 1;
      go(x(0, {6'h3f, o[5:2], o[1:0] | r.regL[3:2]}, i == 4));
    end
    mk(dmb_pkg::MODE_DIRECT, 14'h011, 0, 1);
    go(x(0, 0, 1));
    mk(dmb_pkg::MODE_IND_DE, 0, 1, 1);
    r.regD = 4'h0;
    r.regE = 4'h2;
    o = r.wdata;
    go(x(0, 14'h002, 0));
    mk(dmb_pkg::MODE_IND_DE, 0, 0, 1);
    r.regD = 4'h0;
    r.regE = 4'h2;
    go(x(2, {6'h0, o}, 0));
    for (int i = 0; i < 16; i++) begin
      mk(i < 8 ? dmb_pkg::MODE_PAIR_WR : dmb_pkg::MODE_PAIR_RD, 0, i < 8, 0);
      r.pairSel = 3'(i);
      if (i < 8) pv[i] = r.wdata;
      go(x(i < 8 ? 2'd3 : 2'd2, {6'h0, pv[i % 8]}, 0));
    end
    idle();
    apb(1, dmb_pkg::REG_PC, 32'h2abc);
    mk(dmb_pkg::MODE_ABS, 14'($urandom), 0, 0);
    go(x(1, r.operand, 0));
    foreach (rels[i]) begin
      mk(dmb_pkg::MODE_REL, {8'h0, rels[i]}, 0, 0);
      go(x(1, 14'h2abc + {{8{rels[i][5]}}, rels[i]}, i > 3));
    end
    mk(dmb_pkg::MODE_CADDR, 14'($urandom), 0, 0);
    go(x(1, {2'b10, r.operand[11:0]}, 0));
    mk(dmb_pkg::MODE_FADDR, 14'($urandom), 0, 0);
    go(x(1, {3'h0, r.operand[10:0]}, 0));
    foreach (tops[i]) begin
      mk(dmb_pkg::MODE_TADDR, {7'h0, tops[i]}, 0, 0);
      go(x(1, {7'h0, tops[i]}, i > 1));
    end
    mk(dmb_pkg::MODE_CADDR, 14'h0345, 1, 0);
    go(x(1, 14'h2345, 0));
    idle();
    pcStep <= 1;
    @(posedge clk);
    ce <= 0;
    repeat (2) @(posedge clk);
    ce <= 1;
    pcStep <= 0;
    apb(0, dmb_pkg::REG_PC, 0);
    chk("pcJump", rd[13:0], 14'h2346);
    repeat (3) @(posedge clk);
    chk("pending", expq.size(), 0);
    conclude();
  end
endmodule
`default_nettype wire
